/* File: src/rsa_cfg.svh */
// Constants for the two-wire address decode front end and its master.
// Assumes a 125 MHz system clock on both ends and a master-made link clock.
`ifndef RSA_CFG_SVH
`define RSA_CFG_SVH

`define RSA_ARRAY_ID     4'ha
`define RSA_BANK_ID      4'hd
`define RSA_DEV_SEL      3'h7
`define RSA_RD_BIT       1'b1
`define RSA_WR_BIT       1'b0
`define RSA_BIT_REL      1'b1
`define RSA_RD_PATTERN   9'h1ff
`define RSA_ADDR_RST     16'h0000
`define RSA_ADDR_STEP    16'h0001
`define RSA_LAST_BIT     4'h7
`define RSA_ACK_SLOT     4'h8
`define RSA_CLK_NS       8
`define RSA_PGM_DLY_NS   200
`define RSA_PGM_DLY_CYC  ((`RSA_PGM_DLY_NS + `RSA_CLK_NS - 1) / `RSA_CLK_NS)
`define RSA_TWC_MS       10
`define RSA_TWC_CYC      ((`RSA_TWC_MS * 1000000) / `RSA_CLK_NS)
`define RSA_SCL_MIN_NS   2500
`define RSA_QTR_CYC      ((`RSA_SCL_MIN_NS / 4 + `RSA_CLK_NS - 1) \
                          / `RSA_CLK_NS)
`define RSA_WAKE_BITS    4'h6
`define RSA_WAKE_SEEN    2'h3
`define RSA_Q_LAST       2'h3
`define RSA_Q_SAMPLE     2'h2

`endif

/* File: src/rsa_pkg.sv */
// Types shared by both ends of the two-wire address decode link.
// Assumes rsa_cfg.svh supplies every number used with these types.
package rsa_pkg;

   typedef enum logic [2:0] {
      P_ADDR  = 3'h0,
      P_WAHI  = 3'h1,
      P_WALO  = 3'h3,
      P_WDATA = 3'h2,
      P_RDATA = 3'h6,
      P_IGN   = 3'h7
   } rsa_phase_t;

   typedef enum logic [1:0] {
      PG_IDLE = 2'h0,
      PG_DLY  = 2'h1,
      PG_BUSY = 2'h3
   } rsa_pgm_t;

   typedef enum logic [2:0] {
      H_IDLE  = 3'h0,
      H_WAKE  = 3'h1,
      H_START = 3'h3,
      H_BITS  = 3'h2,
      H_STOP  = 3'h6
   } rsa_hst_t;

   typedef enum logic [2:0] {
      S_ADR  = 3'h0,
      S_HI   = 3'h1,
      S_LO   = 3'h3,
      S_DAT  = 3'h2,
      S_RADR = 3'h6,
      S_RD   = 3'h7
   } rsa_step_t;

   typedef struct packed {
      logic        scl_s1;
      logic        scl_s2;
      logic        scl_d;
      logic        sda_s1;
      logic        sda_s2;
      logic        sda_d;
      logic        wt_s1;
      logic        wt_s2;
      logic        wt_d;
      logic        start_tog;
      logic        armed;
      logic        link_rst;
      logic [1:0]  rises;
      rsa_pgm_t    pgm;
      logic [31:0] cnt;
   } rsa_dsys_t;

   typedef struct packed {
      logic st1;
      logic bz1;
      logic rs1;
      logic drive;
   } rsa_dneg_t;

   typedef struct packed {
      logic        st2;
      logic        bz2;
      logic        rs2;
      logic        frame_seen;
      logic        last_sda;
      rsa_phase_t  phase;
      logic [3:0]  cnt;
      logic [7:0]  shift;
      logic        ack;
      logic        rw;
      logic        bank;
      logic [15:0] addr;
      logic [7:0]  wa_hi;
      logic [7:0]  wdata;
      logic        wstb;
      logic        wr_tog;
   } rsa_dlnk_t;

   typedef struct packed {
      rsa_hst_t    st;
      rsa_step_t   step;
      logic [1:0]  q;
      logic [15:0] qcnt;
      logic [3:0]  bitn;
      logic [8:0]  tx;
      logic [8:0]  rx;
      logic        rw;
      logic        bank;
      logic        set_addr;
      logic [15:0] addr;
      logic [7:0]  wdata;
      logic [7:0]  rdata;
      logic        acked;
      logic        done;
      logic        scl;
      logic        oe;
      logic        sda_s1;
      logic        sda_s2;
   } rsa_host_t;

endpackage

/* File: src/rsa_link_if.sv */
// Two-wire link between the master end and the device end.
// Resolves the open-drain data wire; the clock is driven by the master.
`timescale 1ns/1ps
interface rsa_link_if;
   logic scl;
   logic sda;
   logic sda_h_o;
   logic sda_h_oe;
   logic sda_d_o;
   logic sda_d_oe;

   // Pull-up wins unless an enabled driver pulls low
   assign sda = ~((sda_h_oe & ~sda_h_o) | (sda_d_oe & ~sda_d_o));

   modport host (output scl, output sda_h_o, output sda_h_oe, input sda);
   modport dev  (input scl, input sda, output sda_d_o, output sda_d_oe);
endinterface

/* File: src/rsa_dev_end.sv */
// Device end: decodes the address byte, word address and write cycle.
// Bit logic runs on the link clock; start, stop and the write cycle
// timer run on clk_i. The master must pulse the link clock after reset.
`timescale 1ns/1ps
`include "rsa_cfg.svh"
module rsa_dev_end
   import rsa_pkg::*;
#(
   parameter int unsigned TWC_CYC = `RSA_TWC_CYC,
   parameter int unsigned DLY_CYC = `RSA_PGM_DLY_CYC
) (
   input  wire logic        clk_i,
   input  wire logic        nrst_i,
   rsa_link_if.dev          lnk,
   input  wire logic [7:0]  rdata_i,
   output logic             target_o,
   output logic             rw_o,
   output logic [15:0]      addr_o,
   output logic [7:0]       wdata_o,
   output logic             wstb_o,
   output logic             busy_o
);

   rsa_dsys_t s_reg;
   rsa_dsys_t s_next;
   rsa_dneg_t n_reg;
   rsa_dneg_t n_next;
   rsa_dlnk_t l_reg;
   rsa_dlnk_t l_next;

   logic       start_det;
   logic       stop_det;
   logic       wr_ev;
   logic       scl_rise;
   logic [7:0] nb;
   logic [7:0] nshift;
   logic       id_ok;
   logic       drive_want;

   // Start and stop are seen only in the system domain, on synced lines
   assign start_det = s_reg.scl_s2 & s_reg.scl_d & s_reg.sda_d & ~s_reg.sda_s2;
   assign stop_det  = s_reg.scl_s2 & s_reg.scl_d & ~s_reg.sda_d & s_reg.sda_s2;
   assign wr_ev     = s_reg.wt_s2 ^ s_reg.wt_d;
   assign scl_rise  = s_reg.scl_s2 & ~s_reg.scl_d;

   always_comb begin
      s_next        = s_reg;
      s_next.scl_s1 = lnk.scl;
      s_next.scl_s2 = s_reg.scl_s1;
      s_next.scl_d  = s_reg.scl_s2;
      s_next.sda_s1 = lnk.sda;
      s_next.sda_s2 = s_reg.sda_s1;
      s_next.sda_d  = s_reg.sda_s2;
      s_next.wt_s1  = l_reg.wr_tog;
      s_next.wt_s2  = s_reg.wt_s1;
      s_next.wt_d   = s_reg.wt_s2;
      if (start_det) begin
         s_next.start_tog = ~s_reg.start_tog;
         s_next.armed     = 1'b0;
      end
      // An acked data byte in the same cycle as a start still arms
      if (wr_ev) begin
         s_next.armed = 1'b1;
      end
      // Link side leaves reset only after it has seen a few clock edges
      if (s_reg.link_rst & scl_rise) begin
         if (s_reg.rises == `RSA_WAKE_SEEN) begin
            s_next.link_rst = 1'b0;
         end else begin
            s_next.rises = s_reg.rises + 2'h1;
         end
      end
      unique case (s_reg.pgm)
         PG_IDLE: begin
            if (stop_det & s_reg.armed) begin
               s_next.pgm   = PG_DLY;
               s_next.cnt   = 32'h0;
               s_next.armed = 1'b0;
            end
         end
         PG_DLY: begin
            if (s_reg.cnt == DLY_CYC - 1) begin
               s_next.pgm = PG_BUSY;
               s_next.cnt = 32'h0;
            end else begin
               s_next.cnt = s_reg.cnt + 32'h1;
            end
         end
         PG_BUSY: begin
            // Delay plus busy time never exceeds the write cycle limit
            if (s_reg.cnt >= TWC_CYC - DLY_CYC - 1) begin
               s_next.pgm = PG_IDLE;
               s_next.cnt = 32'h0;
            end else begin
               s_next.cnt = s_reg.cnt + 32'h1;
            end
         end
         default: begin
            s_next.pgm = PG_IDLE;
            s_next.cnt = 32'h0;
         end
      endcase
      if (!nrst_i) begin
         s_next          = '0;
         s_next.link_rst = 1'b1;
         s_next.pgm      = PG_IDLE;
      end
   end

   always_ff @(posedge clk_i) begin
      s_reg <= s_next;
   end

   // Falling link edge: first sync stage and the open-drain driver
   always_comb begin
      n_next       = n_reg;
      n_next.st1   = s_reg.start_tog;
      n_next.bz1   = s_reg.pgm[0];
      n_next.rs1   = s_reg.link_rst;
      n_next.drive = l_reg.rs2 ? 1'b0 : drive_want;
   end

   always_ff @(negedge lnk.scl) begin
      n_reg <= n_next;
   end

   assign nb    = {l_reg.shift[6:0], lnk.sda};
   assign id_ok = (nb[3:1] == `RSA_DEV_SEL) &&
                  ((nb[7:4] == `RSA_ARRAY_ID) ||
                   (nb[7:4] == `RSA_BANK_ID));
   assign drive_want = l_reg.ack |
                       ((l_reg.phase == P_RDATA) &&
                        (l_reg.cnt != `RSA_ACK_SLOT) && ~l_reg.shift[7]);
   assign nshift = (l_reg.phase == P_RDATA) ? {l_reg.shift[6:0], 1'b0}
                                            : nb;

   // Rising link edge: sample data, count bits, decode bytes
   always_comb begin
      l_next      = l_reg;
      l_next.st2  = n_reg.st1;
      l_next.bz2  = n_reg.bz1;
      l_next.rs2  = n_reg.rs1;
      l_next.wstb = 1'b0;
      l_next.last_sda = lnk.sda;
      if (l_reg.st2 != l_reg.frame_seen) begin
         // Start crosses in one rise late, so the bit before it is kept
         l_next.frame_seen = l_reg.st2;
         l_next.phase      = P_ADDR;
         l_next.shift      = {6'h00, l_reg.last_sda, lnk.sda};
         l_next.cnt        = 4'h2;
         l_next.ack        = 1'b0;
      end else if (l_reg.cnt == `RSA_LAST_BIT) begin
         l_next.cnt   = `RSA_ACK_SLOT;
         l_next.shift = nshift;
         unique case (l_reg.phase)
            P_ADDR: begin
               if (id_ok && !l_reg.bz2) begin
                  l_next.ack  = 1'b1;
                  l_next.rw   = nb[0];
                  l_next.bank = (nb[7:4] == `RSA_BANK_ID);
               end else begin
                  l_next.phase = P_IGN;
               end
            end
            P_WAHI: begin
               l_next.wa_hi = nb;
               l_next.ack   = 1'b1;
            end
            P_WALO: begin
               l_next.addr = {l_reg.wa_hi, nb};
               l_next.ack  = 1'b1;
            end
            P_WDATA: begin
               l_next.wdata = nb;
               l_next.wstb  = 1'b1;
               l_next.ack   = 1'b1;
            end
            P_RDATA, P_IGN: begin
               l_next.ack = 1'b0;
            end
         endcase
      end else if (l_reg.cnt == `RSA_ACK_SLOT) begin
         l_next.cnt = 4'h0;
         l_next.ack = 1'b0;
         unique case (l_reg.phase)
            P_ADDR: begin
               if (l_reg.rw == `RSA_RD_BIT) begin
                  // Read uses the counter, not a fresh word address
                  l_next.phase = P_RDATA;
                  l_next.shift = rdata_i;
                  l_next.addr  = l_reg.addr + `RSA_ADDR_STEP;
               end else begin
                  l_next.phase = P_WAHI;
               end
            end
            P_WAHI: begin
               l_next.phase = P_WALO;
            end
            P_WALO: begin
               l_next.phase = P_WDATA;
            end
            P_WDATA: begin
               // Only a full byte plus its acknowledge arms a write
               l_next.wr_tog = ~l_reg.wr_tog;
               l_next.addr   = l_reg.addr + `RSA_ADDR_STEP;
            end
            P_RDATA: begin
               if (lnk.sda == `RSA_BIT_REL) begin
                  l_next.phase = P_IGN;
               end else begin
                  l_next.shift = rdata_i;
                  l_next.addr  = l_reg.addr + `RSA_ADDR_STEP;
               end
            end
            P_IGN: begin
               l_next.phase = P_IGN;
            end
         endcase
      end else begin
         l_next.cnt   = l_reg.cnt + 4'h1;
         l_next.shift = nshift;
      end
      if (l_reg.rs2) begin
         l_next.frame_seen = l_reg.st2;
         l_next.phase      = P_IGN;
         l_next.cnt        = 4'h0;
         l_next.ack        = 1'b0;
         l_next.addr       = `RSA_ADDR_RST;
         l_next.wr_tog     = 1'b0;
      end
   end

   always_ff @(posedge lnk.scl) begin
      l_reg <= l_next;
   end

   assign lnk.sda_d_o  = 1'b0;
   assign lnk.sda_d_oe = n_reg.drive;
   assign target_o     = l_reg.bank;
   assign rw_o         = l_reg.rw;
   assign addr_o       = l_reg.addr;
   assign wdata_o      = l_reg.wdata;
   assign wstb_o       = l_reg.wstb;
   assign busy_o       = s_reg.pgm[1];

endmodule

/* File: src/rsa_host_end.sv */
// Master end: makes the link clock by a divider and runs the byte
// sequences for write, current read, random read and ack polling.
// Assumes the device end sits on the same rsa_link_if.
`timescale 1ns/1ps
`include "rsa_cfg.svh"
module rsa_host_end
   import rsa_pkg::*;
#(
   parameter logic [15:0] QTR_CYC = 16'(`RSA_QTR_CYC)
) (
   input  wire logic        clk_i,
   input  wire logic        nrst_i,
   rsa_link_if.host         lnk,
   input  wire logic        req_i,
   input  wire logic        rw_i,
   input  wire logic        bank_i,
   input  wire logic        set_addr_i,
   input  wire logic [15:0] word_addr_i,
   input  wire logic [7:0]  wdata_i,
   output logic             ready_o,
   output logic             done_o,
   output logic             acked_o,
   output logic [7:0]       rdata_o
);

   rsa_host_t h_reg;
   rsa_host_t h_next;
   logic      tick;

   function automatic logic [8:0] tx_for(input rsa_step_t stp,
                                         input rsa_host_t h);
      logic [3:0] id;
      logic [6:0] sel;
      id  = h.bank ? `RSA_BANK_ID : `RSA_ARRAY_ID;
      sel = {id, `RSA_DEV_SEL};
      unique case (stp)
         S_ADR:  tx_for = {sel, `RSA_WR_BIT, `RSA_BIT_REL};
         S_RADR: tx_for = {sel, `RSA_RD_BIT, `RSA_BIT_REL};
         S_HI:   tx_for = {h.addr[15:8], `RSA_BIT_REL};
         S_LO:   tx_for = {h.addr[7:0], `RSA_BIT_REL};
         S_DAT:  tx_for = {h.wdata, `RSA_BIT_REL};
         S_RD:   tx_for = `RSA_RD_PATTERN;
      endcase
   endfunction

   assign tick = (h_reg.qcnt == QTR_CYC - 16'h1);

   always_comb begin
      h_next        = h_reg;
      h_next.sda_s1 = lnk.sda;
      h_next.sda_s2 = h_reg.sda_s1;
      h_next.done   = 1'b0;
      if (tick) begin
         h_next.qcnt = 16'h0;
         h_next.q    = h_reg.q + 2'h1;
      end else begin
         h_next.qcnt = h_reg.qcnt + 16'h1;
      end
      if (h_reg.st == H_IDLE) begin
         h_next.qcnt = 16'h0;
         h_next.q    = 2'h0;
         if (req_i) begin
            h_next.st       = H_START;
            h_next.rw       = rw_i;
            h_next.bank     = bank_i;
            h_next.set_addr = set_addr_i;
            h_next.addr     = word_addr_i;
            h_next.wdata    = wdata_i;
            // Random read goes through a dummy write of the address
            h_next.step     = (rw_i & ~set_addr_i) ? S_RADR : S_ADR;
         end
      end else if (tick) begin
         if (h_reg.q == `RSA_Q_SAMPLE) begin
            h_next.rx = {h_reg.rx[7:0], h_reg.sda_s2};
         end
         if (h_reg.q == `RSA_Q_LAST) begin
            unique case (h_reg.st)
               H_WAKE: begin
                  if (h_reg.bitn == `RSA_WAKE_BITS - 4'h1) begin
                     h_next.st   = H_IDLE;
                     h_next.bitn = 4'h0;
                  end else begin
                     h_next.bitn = h_reg.bitn + 4'h1;
                  end
               end
               H_START: begin
                  h_next.st   = H_BITS;
                  h_next.bitn = 4'h0;
                  h_next.tx   = tx_for(h_reg.step, h_reg);
               end
               H_BITS: begin
                  if (h_reg.bitn == `RSA_ACK_SLOT) begin
                     h_next.bitn = 4'h0;
                     unique case (h_reg.step)
                        S_ADR, S_RADR: begin
                           h_next.acked = ~h_next.rx[0];
                           if (h_next.rx[0]) begin
                              h_next.st = H_STOP;
                           end else begin
                              h_next.step = (h_reg.step == S_ADR) ? S_HI : S_RD;
                           end
                        end
                        S_HI: begin
                           h_next.step = S_LO;
                        end
                        S_LO: begin
                           if (h_reg.rw) begin
                              h_next.step = S_RADR;
                              h_next.st   = H_START;
                           end else begin
                              h_next.step = S_DAT;
                           end
                        end
                        S_DAT: begin
                           h_next.st = H_STOP;
                        end
                        S_RD: begin
                           h_next.rdata = h_next.rx[8:1];
                           h_next.st    = H_STOP;
                        end
                     endcase
                     h_next.tx = tx_for(h_next.step, h_reg);
                  end else begin
                     h_next.bitn = h_reg.bitn + 4'h1;
                     h_next.tx   = {h_reg.tx[7:0], `RSA_BIT_REL};
                  end
               end
               H_STOP: begin
                  h_next.st   = H_IDLE;
                  h_next.done = 1'b1;
               end
               default: begin
                  h_next.st = H_IDLE;
               end
            endcase
         end
      end
      // Pin levels follow the next state so both pins come from flops
      unique case (h_next.st)
         H_IDLE: begin
            h_next.scl = 1'b1;
            h_next.oe  = 1'b0;
         end
         H_WAKE: begin
            h_next.scl = h_next.q[1];
            h_next.oe  = 1'b0;
         end
         H_START: begin
            h_next.scl = (h_next.q != 2'h0);
            h_next.oe  = h_next.q[1];
         end
         H_BITS: begin
            h_next.scl = h_next.q[1];
            h_next.oe  = ~h_next.tx[8];
         end
         H_STOP: begin
            h_next.scl = (h_next.q != 2'h0);
            h_next.oe  = ~h_next.q[1];
         end
         default: begin
            h_next.scl = 1'b1;
            h_next.oe  = 1'b0;
         end
      endcase
      if (!nrst_i) begin
         h_next      = '0;
         h_next.st   = H_WAKE;
         h_next.step = S_ADR;
         h_next.scl  = 1'b1;
      end
   end

   always_ff @(posedge clk_i) begin
      h_reg <= h_next;
   end

   assign lnk.scl      = h_reg.scl;
   assign lnk.sda_h_o  = 1'b0;
   assign lnk.sda_h_oe = h_reg.oe;
   assign ready_o      = (h_reg.st == H_IDLE);
   assign done_o       = h_reg.done;
   assign acked_o      = h_reg.acked;
   assign rdata_o      = h_reg.rdata;

endmodule

/* File: sim/rsa_link_sva.sv */
// Concurrent checks on the two-wire link, the write cycle busy flag and the master done flag.
// Assumes the bench feeds it the link signals and two flags by name.
`timescale 1ns/1ps
module rsa_link_sva #(
   parameter int unsigned TWC_CYC = 1000,
   parameter int unsigned DLY_CYC = 25
) (
   input  wire logic clk_i,
   input  wire logic nrst_i,
   input  wire logic scl,
   input  wire logic sda,
   input  wire logic sda_h_o,
   input  wire logic sda_h_oe,
   input  wire logic sda_d_o,
   input  wire logic sda_d_oe,
   input  wire logic busy_o,
   input  wire logic done_o
);
   logic        sda_q;
   logic [15:0] scnt;
   logic [31:0] bcnt;

   // Saturating counter since the last stop; busy run length
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         sda_q <= 1'b1;
         scnt  <= 16'hffff;
         bcnt  <= 32'h0;
      end else begin
         sda_q <= sda;
         if (scl && sda && !sda_q)
            scnt <= 16'h0;
         else if (scnt != 16'hffff)
            scnt <= scnt + 16'h1;
         bcnt <= busy_o ? bcnt + 32'h1 : 32'h0;
      end
   end

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!nrst_i);

   chk_host_open_drain: assert property (sda_h_o == 1'b0)
      else $error("host data out not low");
   chk_dev_open_drain: assert property (sda_d_o == 1'b0)
      else $error("device data out not low");
   // Moving sda under a high clock would read as start or stop
   chk_dev_edge_low: assert property ($changed(sda_d_oe) |-> !scl)
      else $error("device sda changed while scl high");
   chk_busy_no_ack: assert property (busy_o |-> !sda_d_oe)
      else $error("device drives sda during write cycle");
   chk_busy_hold: assert property ($rose(busy_o) |=> busy_o [*8])
      else $error("busy dropped early");
   chk_busy_len: assert property (
      $fell(busy_o) |-> bcnt == TWC_CYC - DLY_CYC)
      else $error("busy length wrong");
   chk_pgm_delay: assert property (
      $rose(busy_o) |-> scnt >= DLY_CYC && scnt <= DLY_CYC + 6)
      else $error("busy not 200 ns after stop");
   chk_done_pulse: assert property (done_o |=> !done_o)
      else $error("done longer than one cycle");
   chk_done_idle: assert property (
      done_o |-> scl && sda && !sda_h_oe)
      else $error("done before bus released");
   chk_start_free: assert property (
      scl && $fell(sda) |-> !sda_d_oe)
      else $error("device holds sda at start");

   cover property ($rose(busy_o));
   cover property ($rose(sda_d_oe));
   cover property (done_o);
endmodule

/* File: sim/rtc_eeprom_serial_addressing_test.sv */
// Bench joining master end and device end across one link.
// Assumes host request port timing as handed over; memory is a function.
`timescale 1ns/1ps
module rtc_eeprom_serial_addressing_test;
   import rsa_pkg::*;
   localparam int unsigned NONVOLATILE_WRITE_CYCLE_TIME = 1000;
   logic        clk_i, nrst_i, req_i, rw_i, bank_i, set_addr_i;
   logic [15:0] word_addr_i, addr_o;
   logic [7:0]  wdata_i, rdata_o, rdata_i, wdata_o;
   logic        ready_o, done_o, acked_o, target_o, rw_o, busy_o;
   int          fails, n_checks;
   logic        wstb_o, wstb_q;
   int          n_wstb = 0;

   rsa_link_if lnk_i ();
   rsa_host_end #(.QTR_CYC(16'h8)) rsa_host_end_i (
      .clk_i(clk_i), .nrst_i(nrst_i), .lnk(lnk_i), .req_i(req_i),
      .rw_i(rw_i), .bank_i(bank_i), .set_addr_i(set_addr_i),
      .word_addr_i(word_addr_i), .wdata_i(wdata_i), .ready_o(ready_o),
      .done_o(done_o), .acked_o(acked_o), .rdata_o(rdata_o));
   rsa_dev_end #(.TWC_CYC(NONVOLATILE_WRITE_CYCLE_TIME), .DLY_CYC(25)) rsa_dev_end_i (
      .clk_i(clk_i), .nrst_i(nrst_i), .lnk(lnk_i), .rdata_i(rdata_i),
      .target_o(target_o), .rw_o(rw_o), .addr_o(addr_o),
      .wdata_o(wdata_o), .wstb_o(wstb_o), .busy_o(busy_o));
   rsa_link_sva #(.TWC_CYC(NONVOLATILE_WRITE_CYCLE_TIME), .DLY_CYC(25)) rsa_link_sva_i (
      .clk_i(clk_i), .nrst_i(nrst_i), .scl(lnk_i.scl), .sda(lnk_i.sda),
      .sda_h_o(lnk_i.sda_h_o), .sda_h_oe(lnk_i.sda_h_oe),
      .sda_d_o(lnk_i.sda_d_o), .sda_d_oe(lnk_i.sda_d_oe),
      .busy_o(busy_o), .done_o(done_o));

   // Memory contents are a plain function of the address
   function automatic logic [7:0] mem(input logic [15:0] a);
      return a[7:0] ^ 8'h5a;
   endfunction

   always @(posedge clk_i) rdata_i <= mem(addr_o);

   // Count write strobes by their rising edge on the system clock
   always @(posedge clk_i) begin
      wstb_q <= wstb_o;
      if (wstb_o === 1'b1 && wstb_q !== 1'b1)
         n_wstb <= n_wstb + 1;
   end

   initial begin
      clk_i = 1'b0;
      forever #4 clk_i = ~clk_i;
   end

   task automatic chk(input string what, input logic [15:0] exp,
                      input logic [15:0] got);
      n_checks++;
      if (got !== exp) begin
         fails++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic give_verdict;
      $display("checks %0d fails %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   // One whole frame: wait idle, post request, wait for done
   task automatic xfer(input logic rw, input logic bank, input logic sa,
                       input logic [15:0] a, input logic [7:0] d);
      int n;
      n = 0;
      do begin
         @(negedge clk_i);
         n++;
      end while (ready_o !== 1'b1 && n < 5000);
      if (n >= 5000) begin
         fails++;
         $display("MISMATCH ready expected 1 seen 0");
      end
      @(posedge clk_i);
      req_i       <= 1'b1;
      rw_i        <= rw;
      bank_i      <= bank;
      set_addr_i  <= sa;
      word_addr_i <= a;
      wdata_i     <= d;
      @(posedge clk_i);
      req_i <= 1'b0;
      n = 0;
      do begin
         @(negedge clk_i);
         n++;
      end while (done_o !== 1'b1 && n < 5000);
      if (n >= 5000) begin
         fails++;
         $display("MISMATCH done expected 1 seen 0");
      end
   endtask

   initial begin
      #600000;
      fails++;
      give_verdict();
   end

   initial begin
      logic [15:0] a;
      logic [7:0]  d;
      int          k;
      nrst_i = 1'b0; req_i = 1'b0; rw_i = 1'b0; bank_i = 1'b0;
      set_addr_i = 1'b0; word_addr_i = 16'h0; wdata_i = 8'h0;
      fails = 0; n_checks = 0;
      repeat (4) @(posedge clk_i);
      nrst_i <= 1'b1;
      xfer(1'b1, 1'b0, 1'b0, 16'h0, 8'h0);
      chk("acked", 16'h1, 16'(acked_o));
      chk("rdata", 16'(mem(16'h0)), 16'(rdata_o));
      chk("rw", 16'h1, 16'(rw_o));
      chk("target", 16'h0, 16'(target_o));
      chk("addr", 16'h1, addr_o);
      $display("test current_read done");
      xfer(1'b1, 1'b1, 1'b1, 16'h1234, 8'h0);
      chk("rdata", 16'(mem(16'h1234)), 16'(rdata_o));
      chk("target", 16'h1, 16'(target_o));
      chk("addr", 16'h1235, addr_o);
      $display("test random_read done");
      // Array write, then bank write at the top address to see wrap
      for (int b = 0; b < 2; b++) begin
         a = b[0] ? 16'hffff : 16'h0a0b;
         d = b[0] ? 8'h3c : 8'hc3;
         xfer(1'b0, b[0], 1'b1, a, d);
         chk("acked", 16'h1, 16'(acked_o));
         chk("wdata", 16'(d), 16'(wdata_o));
         chk("wstb count", 16'(b + 1), 16'(n_wstb));
         chk("rw", 16'h0, 16'(rw_o));
         chk("target", 16'(b[0]), 16'(target_o));
         chk("addr", 16'(a + 16'h1), addr_o);
         xfer(1'b1, b[0], 1'b0, 16'h0, 8'h0);
         chk("poll acked", 16'h0, 16'(acked_o));
         chk("busy", 16'h1, 16'(busy_o));
         k = 0;
         while (acked_o !== 1'b1 && k < 20) begin
            xfer(1'b1, b[0], 1'b0, 16'h0, 8'h0);
            k++;
         end
         chk("poll acked", 16'h1, 16'(acked_o));
         chk("rdata", 16'(mem(16'(a + 16'h1))), 16'(rdata_o));
         chk("busy", 16'h0, 16'(busy_o));
         $display("test write_poll %0d done", b);
      end
      give_verdict();
   end
endmodule
